// ==== src/cbt_top.sv ====
// CAN bit timing engine, triple transmit buffer and frame sender
// Notes on behaviour
// - Timing register 0 writable only in init
// - Jump width code n means n+1 quanta
// - Prescaler field divides clock into quanta
// - Three independent transmit buffers
// - Each buffer holds 13 message bytes
// - Each buffer has writable 8-bit priority
// - Each buffer has two time stamp bytes
// - Empty flag set when buffer is free
// - Only selected buffer appears in window
// - Highest priority ready buffer sent first
// - Back-to-back frames; release only on success
// - Edges in sync segment need no correction
// - New bit driven at transmit point
// - Sample point; third sample with triple
// - Segments and jump width from timing registers
// - Sequencer held idle, bus recessive in init
// - Acknowledge set only once idle reached
`timescale 1ns/100ps
`include "cbt_defines.svh"
module cbt_top (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic can_rx_in,
    output logic can_tx_out,
    output logic init_ack_out
);
    cbt_mem_if mem_bus ();

    cbt_pkg::cbt_state_e state_reg;
    logic init_req_reg;
    logic init_ack_reg;
    cbt_pkg::cbt_byte_t bt0_reg;
    cbt_pkg::cbt_byte_t bt1_reg;
    logic [2:0] empty_reg;
    logic [2:0] sel_reg;
    cbt_pkg::cbt_byte_t local_priority_reg [0:2];
    logic [15:0] ts_reg [0:2];
    logic [15:0] ts_cnt_reg;
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    logic [5:0] presc_reg;
    logic [5:0] pos_reg;
    logic [2:0] ext_reg;
    logic [2:0] shr_reg;
    logic synced_reg;
    logic restart_reg;
    logic [1:0] samp_sh_reg;
    logic tx_reg;
    logic [1:0] cur_buf_reg;
    logic [3:0] byte_cnt_reg;
    logic [2:0] bit_cnt_reg;
    cbt_pkg::cbt_byte_t shift_reg;
    logic [3:0] len_reg;
    logic [3:0] eof_cnt_reg;
    logic [3:0] idle_cnt_reg;

    logic run;
    logic in_init;
    logic win_hit;
    logic [3:0] win_idx;
    logic sel_ok;
    logic [1:0] sel_idx;
    logic win_wr;
    logic [2:0] sel_mask;
    logic [2:0] sel_next;
    logic [2:0] jump_len;
    logic [5:0] tseg1_end;
    logic [5:0] bit_last;
    logic [5:0] remain;
    logic fall;
    logic edge_ok;
    logic bus_idle;
    logic hard_sync;
    logic tq_tick;
    logic bit_end;
    logic sample;
    logic rx_val;
    logic [1:0] best_idx;
    logic any_ready;
    logic can_start;
    logic frame_done;
    logic done;
    logic [3:0] load_idx;
    cbt_pkg::cbt_byte_t rdat;

    assign run = ~init_ack_reg;
    assign in_init = init_req_reg & init_ack_reg;
    assign can_tx_out = tx_reg;
    assign init_ack_out = init_ack_reg;
    assign rdata_out = mem_bus.cpu_rdata;

    // Buffer window decode
    assign win_hit = addr_in[5:4] == `CBT_WIN_PAGE;
    assign win_idx = addr_in[3:0];
    assign sel_ok = |sel_reg;
    assign sel_idx = sel_reg[2] ? 2'd2 : (sel_reg[1] ? 2'd1 : 2'd0);
    // Queued buffers are locked against writes until sent
    assign win_wr = wr_in & win_hit & sel_ok & empty_reg[sel_idx];
    assign sel_mask = wdata_in[2:0] & empty_reg;
    assign sel_next = sel_mask & (~sel_mask + 3'd1);

    assign mem_bus.wr_en = win_wr & (win_idx < `CBT_MSG_BYTES);
    assign mem_bus.wr_addr = {sel_idx, win_idx};
    assign mem_bus.wr_data = wdata_in;
    assign mem_bus.cpu_rd = rd_in;
    assign mem_bus.cpu_win = win_hit & sel_ok & (win_idx < `CBT_MSG_BYTES);
    assign mem_bus.cpu_addr = {sel_idx, win_idx};
    assign mem_bus.alt_data = rdat;
    assign mem_bus.tx_addr = {cur_buf_reg, load_idx};

    always_comb begin
        rdat = 8'h00;
        if (win_hit) begin
            if (sel_ok) begin
                case (win_idx)
                    `CBT_WIN_LOCAL_PRIORITY: rdat = local_priority_reg[sel_idx];
                    `CBT_WIN_TSH: rdat = ts_reg[sel_idx][15:8];
                    `CBT_WIN_TSL: rdat = ts_reg[sel_idx][7:0];
                    default: rdat = 8'h00;
                endcase
            end
        end else begin
            case (addr_in)
                `CBT_OFS_CTL0: rdat = {7'h00, init_req_reg};
                `CBT_OFS_CTL1: rdat = {7'h00, init_ack_reg};
                `CBT_OFS_BT0: rdat = bt0_reg;
                `CBT_OFS_BT1: rdat = bt1_reg;
                `CBT_OFS_TXFLG: rdat = {5'h00, empty_reg};
                `CBT_OFS_TBSEL: rdat = {5'h00, sel_reg};
                default: rdat = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_req_reg <= `CBT_RST_INIT_REQ;
        end else if (wr_in && addr_in == `CBT_OFS_CTL0) begin
            init_req_reg <= wdata_in[0];
        end
    end

    // Never acknowledge mid-frame: wait for the sequencer to idle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_ack_reg <= 1'b0;
        end else if (!init_req_reg) begin
            init_ack_reg <= 1'b0;
        end else if (state_reg == cbt_pkg::ST_IDLE) begin
            init_ack_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bt0_reg <= `CBT_RST_BT0;
            bt1_reg <= `CBT_RST_BT1;
        end else if (wr_in && in_init) begin
            if (addr_in == `CBT_OFS_BT0) begin
                bt0_reg <= wdata_in;
            end
            if (addr_in == `CBT_OFS_BT1) begin
                bt1_reg <= wdata_in;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            empty_reg <= `CBT_RST_EMPTY;
        end else begin
            empty_reg <= (empty_reg
                & ~((wr_in && addr_in == `CBT_OFS_TXFLG) ? wdata_in[2:0]
                                                          : 3'h0))
                | (done ? (3'h1 << cur_buf_reg) : 3'h0);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_reg <= 3'h0;
        end else if (wr_in && addr_in == `CBT_OFS_TBSEL) begin
            sel_reg <= sel_next;
        end
    end

    // Per-buffer priority and time stamp
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 3; i++) begin
                local_priority_reg[i] <= 8'h00;
                ts_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (win_wr && win_idx == `CBT_WIN_LOCAL_PRIORITY && sel_idx == 2'(i)) begin
                    local_priority_reg[i] <= wdata_in;
                end
                if (done && cur_buf_reg == 2'(i)) begin
                    ts_reg[i] <= ts_cnt_reg;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ts_cnt_reg <= 16'h0000;
        end else if (bit_end) begin
            ts_cnt_reg <= ts_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx_in;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // Bit timing geometry in quanta
    assign jump_len = {1'b0, bt0_reg[`CBT_BT0_JW_MSB:`CBT_BT0_JW_LSB]}
        + 3'd1;
    assign tseg1_end = {2'b00, bt1_reg[`CBT_BT1_TS1_MSB:0]} + 6'd1
        + {3'b000, ext_reg};
    assign bit_last = tseg1_end
        + {3'b000, bt1_reg[`CBT_BT1_TS2_MSB:`CBT_BT1_TS2_LSB]} + 6'd1
        - {3'b000, shr_reg};
    assign remain = bit_last - pos_reg + 6'd1;
    assign tq_tick = run && presc_reg == bt0_reg[`CBT_BT0_PRE_MSB:0];
    assign bit_end = tq_tick & (pos_reg == bit_last | restart_reg);
    assign sample = tq_tick & pos_reg == tseg1_end & ~restart_reg;
    assign fall = rx_prev_reg & ~rx_sync_reg;
    // A node driving dominant does not resync on its own edge
    assign edge_ok = run & fall & ~synced_reg
        & ~(state_reg == cbt_pkg::ST_SEND & ~tx_reg);
    assign bus_idle = idle_cnt_reg == `CBT_IDLE_BITS;
    assign hard_sync = edge_ok & bus_idle & (state_reg == cbt_pkg::ST_IDLE);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            presc_reg <= 6'h00;
        end else if (!run || hard_sync || tq_tick) begin
            presc_reg <= 6'h00;
        end else begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pos_reg <= 6'h00;
        end else if (!run || hard_sync || bit_end) begin
            pos_reg <= 6'h00;
        end else if (tq_tick) begin
            pos_reg <= pos_reg + 6'h01;
        end
    end

    // Resync: late edge stretches segment 1, early edge trims segment 2
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_reg <= 3'h0;
            shr_reg <= 3'h0;
            restart_reg <= 1'b0;
            synced_reg <= 1'b0;
        end else if (!run || hard_sync || bit_end) begin
            ext_reg <= 3'h0;
            shr_reg <= 3'h0;
            restart_reg <= 1'b0;
            synced_reg <= hard_sync;
        end else if (edge_ok && pos_reg != 6'h00) begin
            synced_reg <= 1'b1;
            if (pos_reg <= tseg1_end) begin
                ext_reg <= (pos_reg <= {3'b000, jump_len}) ? pos_reg[2:0]
                                                          : jump_len;
            end else if (remain <= {3'b000, jump_len}) begin
                restart_reg <= 1'b1;
            end else begin
                shr_reg <= jump_len;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            samp_sh_reg <= 2'h3;
        end else if (tq_tick) begin
            samp_sh_reg <= {samp_sh_reg[0], rx_sync_reg};
        end
    end

    // Majority of the last three quanta, third one at the sample point
    assign rx_val = bt1_reg[`CBT_BT1_SAMP3]
        ? ((samp_sh_reg[1] & samp_sh_reg[0])
           | (samp_sh_reg[1] & rx_sync_reg)
           | (samp_sh_reg[0] & rx_sync_reg))
        : rx_sync_reg;

    // Lowest value wins; ties go to the lowest buffer
    always_comb begin
        best_idx = 2'd0;
        any_ready = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (!empty_reg[i]
                && (!any_ready || local_priority_reg[i] < local_priority_reg[best_idx])) begin
                best_idx = 2'(i);
                any_ready = 1'b1;
            end
        end
    end

    assign can_start = any_ready & ~init_req_reg;
    assign load_idx = (byte_cnt_reg < `CBT_ID_BYTES) ? byte_cnt_reg
        : ((byte_cnt_reg == `CBT_ID_BYTES) ? `CBT_LEN_IDX
                                           : byte_cnt_reg - 4'h1);
    assign frame_done = byte_cnt_reg > `CBT_ID_BYTES
        && byte_cnt_reg == `CBT_ID_BYTES + 4'h1 + len_reg;
    assign done = state_reg == cbt_pkg::ST_SEND && bit_end
        && bit_cnt_reg == 3'h0 && frame_done;

    // Frame sequencer, held in ST_IDLE with the bus recessive in init mode
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= cbt_pkg::ST_IDLE;
            tx_reg <= 1'b1;
            cur_buf_reg <= 2'd0;
            byte_cnt_reg <= 4'h0;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            len_reg <= 4'h0;
            eof_cnt_reg <= 4'h0;
            idle_cnt_reg <= 4'h0;
        end else if (!run) begin
            state_reg <= cbt_pkg::ST_IDLE;
            tx_reg <= 1'b1;
            idle_cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                cbt_pkg::ST_IDLE: begin
                    if (sample) begin
                        idle_cnt_reg <= !rx_val ? 4'h0
                            : (bus_idle ? idle_cnt_reg
                                        : idle_cnt_reg + 4'h1);
                    end
                    if (bit_end && bus_idle && can_start) begin
                        state_reg <= cbt_pkg::ST_SEND;
                        tx_reg <= 1'b0;
                        cur_buf_reg <= best_idx;
                        byte_cnt_reg <= 4'h0;
                        bit_cnt_reg <= 3'h0;
                    end
                end
                cbt_pkg::ST_SEND: begin
                    if (sample && rx_val != tx_reg) begin
                        // Lost arbitration or bit error: buffer stays queued
                        state_reg <= cbt_pkg::ST_IDLE;
                        tx_reg <= 1'b1;
                        idle_cnt_reg <= 4'h0;
                    end else if (bit_end) begin
                        if (bit_cnt_reg != 3'h0) begin
                            tx_reg <= shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg - 3'h1;
                        end else if (frame_done) begin
                            state_reg <= cbt_pkg::ST_EOF;
                            tx_reg <= 1'b1;
                            eof_cnt_reg <= 4'h0;
                        end else begin
                            tx_reg <= mem_bus.tx_rdata[7];
                            shift_reg <= {mem_bus.tx_rdata[6:0], 1'b0};
                            bit_cnt_reg <= 3'h7;
                            byte_cnt_reg <= byte_cnt_reg + 4'h1;
                            if (byte_cnt_reg == `CBT_ID_BYTES) begin
                                len_reg <= (mem_bus.tx_rdata[3:0]
                                    > `CBT_MAX_DATA) ? `CBT_MAX_DATA
                                    : mem_bus.tx_rdata[3:0];
                            end
                        end
                    end
                end
                cbt_pkg::ST_EOF: begin
                    if (bit_end) begin
                        if (eof_cnt_reg != `CBT_EOF_BITS - 4'h1) begin
                            eof_cnt_reg <= eof_cnt_reg + 4'h1;
                        end else if (can_start) begin
                            state_reg <= cbt_pkg::ST_SEND;
                            tx_reg <= 1'b0;
                            cur_buf_reg <= best_idx;
                            byte_cnt_reg <= 4'h0;
                            bit_cnt_reg <= 3'h0;
                        end else begin
                            state_reg <= cbt_pkg::ST_IDLE;
                            idle_cnt_reg <= `CBT_IDLE_BITS;
                        end
                    end
                end
            endcase
        end
    end

    cbt_msg_mem u_mem (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .bus(mem_bus.mem)
    );
endmodule

// ==== src/cbt_defines.svh ====
// Register offsets, field positions, reset values and bit counts
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

`define CBT_OFS_CTL0 6'h00
`define CBT_OFS_CTL1 6'h01
`define CBT_OFS_BT0 6'h02
`define CBT_OFS_BT1 6'h03
`define CBT_OFS_TXFLG 6'h04
`define CBT_OFS_TBSEL 6'h05
`define CBT_WIN_PAGE 2'h1
`define CBT_WIN_LOCAL_PRIORITY 4'hd
`define CBT_WIN_TSH 4'he
`define CBT_WIN_TSL 4'hf

`define CBT_MSG_BYTES 4'hd
`define CBT_LEN_IDX 4'hc
`define CBT_ID_BYTES 4'h4
`define CBT_MAX_DATA 4'h8
`define CBT_MEM_DEPTH 48

`define CBT_BT0_JW_MSB 7
`define CBT_BT0_JW_LSB 6
`define CBT_BT0_PRE_MSB 5
`define CBT_BT1_SAMP3 7
`define CBT_BT1_TS2_MSB 6
`define CBT_BT1_TS2_LSB 4
`define CBT_BT1_TS1_MSB 3

`define CBT_RST_BT0 8'h00
`define CBT_RST_BT1 8'h00
`define CBT_RST_INIT_REQ 1'b1
`define CBT_RST_EMPTY 3'h7

`define CBT_IDLE_BITS 4'hb
`define CBT_EOF_BITS 4'ha

`endif

// ==== src/cbt_pkg.sv ====
// Types shared by the bit timing and transmit buffer block
package cbt_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_EOF = 3'h4
    } cbt_state_e;
    typedef logic [7:0] cbt_byte_t;
endpackage

// ==== src/cbt_mem_if.sv ====
// Link between the controller and its message memory
`timescale 1ns/100ps
interface cbt_mem_if;
    logic wr_en;
    logic [5:0] wr_addr;
    cbt_pkg::cbt_byte_t wr_data;
    logic cpu_rd;
    logic cpu_win;
    logic [5:0] cpu_addr;
    cbt_pkg::cbt_byte_t alt_data;
    cbt_pkg::cbt_byte_t cpu_rdata;
    logic [5:0] tx_addr;
    cbt_pkg::cbt_byte_t tx_rdata;
    modport ctl (
        output wr_en, wr_addr, wr_data, cpu_rd, cpu_win, cpu_addr,
        output alt_data, tx_addr,
        input cpu_rdata, tx_rdata
    );
    modport mem (
        input wr_en, wr_addr, wr_data, cpu_rd, cpu_win, cpu_addr,
        input alt_data, tx_addr,
        output cpu_rdata, tx_rdata
    );
endinterface

// ==== src/cbt_msg_mem.sv ====
// Message storage for the three transmit buffers
`timescale 1ns/100ps
`include "cbt_defines.svh"
module cbt_msg_mem (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    cbt_mem_if.mem bus
);
    cbt_pkg::cbt_byte_t mem_array [0:`CBT_MEM_DEPTH-1];

    always_ff @(posedge ref_clk_in) begin
        if (bus.wr_en) begin
            mem_array[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Final read register also carries the non-memory registers,
    // so the bus read data leave a flip-flop directly
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.cpu_rdata <= 8'h00;
        end else if (bus.cpu_rd) begin
            bus.cpu_rdata <= bus.cpu_win ? mem_array[bus.cpu_addr]
                                         : bus.alt_data;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.tx_rdata <= 8'h00;
        end else begin
            bus.tx_rdata <= mem_array[bus.tx_addr];
        end
    end
endmodule

// ==== tb/cbt_can_node.sv ====
// Other node sharing the bus with the block under test
`timescale 1ns/100ps
module cbt_can_node (
    input wire logic can_tx_in,
    input wire logic clash_in,
    output logic can_rx_out
);
    // Wired-AND with pull-up; a clash wins arbitration over us
    assign can_rx_out = can_tx_in & ~clash_in;
endmodule

// ==== tb/cbt_top_asserts.sv ====
// Port assertions for the bit timing and transmit buffer block
`timescale 1ns/100ps
`include "cbt_defines.svh"
module cbt_top_asserts (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic can_rx_in,
    input wire logic can_tx_out,
    input wire logic init_ack_out
);
    logic req_reg;
    logic [7:0] bt0_reg;
    logic bt0_ok;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    assign bt0_ok = req_reg && init_ack_out;
    // Mirror of the request bit, needed to judge the write lock
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_reg <= `CBT_RST_INIT_REQ;
        end else if (wr_in && addr_in == `CBT_OFS_CTL0) begin
            req_reg <= wdata_in[0];
        end
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bt0_reg <= `CBT_RST_BT0;
        end else if (wr_in && addr_in == `CBT_OFS_BT0 && bt0_ok) begin
            bt0_reg <= wdata_in;
        end
    end

    chk_bt0_lock: assert property (
        rd_in && addr_in == `CBT_OFS_BT0 |=> rdata_out == bt0_reg)
        else $error("timing register 0 holds a refused write");
    chk_rdata_hold: assert property (
        !rd_in |=> $stable(rdata_out))
        else $error("read data moved without a read");
    chk_ack_rise: assert property (
        $rose(init_ack_out) |-> $past(req_reg))
        else $error("acknowledge rose without a request");
    chk_ack_reset: assert property (
        $rose(rstn_in) |-> ##1 init_ack_out)
        else $error("acknowledge missing after reset");
    chk_ack_read: assert property (
        rd_in && addr_in == `CBT_OFS_CTL1
        |=> rdata_out == {7'h00, $past(init_ack_out)})
        else $error("acknowledge read back wrong");
    chk_tx_halt: assert property (
        init_ack_out && $past(init_ack_out) |-> can_tx_out)
        else $error("bus driven while in initialisation");
    chk_tx_hold: assert property (
        $changed(can_tx_out) |=> $stable(can_tx_out))
        else $error("bus level changed inside one quantum");
    chk_unmapped_zero: assert property (
        rd_in && addr_in[5:4] == 2'h0 && addr_in > 6'h05
        |=> rdata_out == 8'h00)
        else $error("unmapped address read nonzero");
endmodule

bind cbt_top cbt_top_asserts i_cbt_top_asserts (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .can_rx_in(can_rx_in),
    .can_tx_out(can_tx_out), .init_ack_out(init_ack_out)
);

// ==== tb/testbench.sv ====
// Self-checking bench for the bit timing and transmit buffer block
`timescale 1ns/100ps
`include "cbt_defines.svh"
module testbench;
    // Prescaler 1 and segments of 5 and 2 quanta: 16 clocks a bit
    localparam int BIT = 16;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [5:0] addr_in = 6'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic clash = 1'b0;
    logic [7:0] rdata_out;
    logic can_rx_in;
    logic can_tx_out;
    logic init_ack_out;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    cbt_top i_cbt_top (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .can_rx_in(can_rx_in),
        .can_tx_out(can_tx_out), .init_ack_out(init_ack_out)
    );
    cbt_can_node i_cbt_can_node (
        .can_tx_in(can_tx_out), .clash_in(clash), .can_rx_out(can_rx_in)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    // Read data are taken at the edge that closes their first cycle
    task automatic peek(input logic [5:0] a, output logic [7:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(posedge ref_clk_in);
        v = rdata_out;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] v;
        peek(a, v);
        check(v, exp);
    endtask
    // Bounded wait for a start of frame, then mid-bit check of it
    task automatic sof(output int t);
        int n = 0;
        while (can_tx_out !== 1'b0 && n < 3000) begin
            @(posedge ref_clk_in);
            #1 n++;
        end
        t = cycles;
        repeat (BIT / 2) @(posedge ref_clk_in);
        #1 check({7'h00, can_tx_out}, 8'h00);
    endtask
    task automatic frame(output logic [7:0] b, output int t);
        sof(t);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge ref_clk_in);
            #1 b = {b[6:0], can_tx_out};
        end
        // Skip the rest of an empty frame so its bits are no false start
        repeat (BIT * 33) @(posedge ref_clk_in);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic t_reset;
        rd(`CBT_OFS_CTL1, 8'h01);
        rd(`CBT_OFS_BT0, `CBT_RST_BT0);
        rd(`CBT_OFS_TXFLG, 8'h07);
        rd(`CBT_OFS_TBSEL, 8'h00);
        rd(6'h0a, 8'h00);
    endtask
    task automatic t_timing;
        for (int j = 0; j < 4; j++) begin
            wr(`CBT_OFS_BT0, {2'(j), 6'h2a});
            rd(`CBT_OFS_BT0, {2'(j), 6'h2a});
        end
        wr(`CBT_OFS_BT0, 8'h01);
        wr(`CBT_OFS_BT1, 8'h94);
        rd(`CBT_OFS_BT1, 8'h94);
    endtask
    // Priorities 0x30, 0x10, 0x20 give send order 1, 2, 0
    task automatic t_buffers;
        wr(`CBT_OFS_TBSEL, 8'h06);
        rd(`CBT_OFS_TBSEL, 8'h02);
        for (int b = 0; b < 3; b++) begin
            wr(`CBT_OFS_TBSEL, 8'h01 << b);
            for (int i = 0; i < 12; i++)
                wr(6'h10 + 6'(i), {4'(b + 1), 4'(i)});
            wr(6'h1c, 8'h00);
            wr(6'h1d, {4'(b == 0 ? 3 : b), 4'h0});
        end
        for (int b = 0; b < 3; b++) begin
            wr(`CBT_OFS_TBSEL, 8'h01 << b);
            rd(`CBT_OFS_TBSEL, 8'h01 << b);
            for (int i = 0; i < 12; i++)
                rd(6'h10 + 6'(i), {4'(b + 1), 4'(i)});
            rd(6'h1c, 8'h00);
            rd(6'h1d, {4'(b == 0 ? 3 : b), 4'h0});
        end
    endtask
    task automatic t_lock;
        wr(`CBT_OFS_CTL0, 8'h00);
        rd(`CBT_OFS_CTL1, 8'h00);
        wr(`CBT_OFS_BT0, 8'h3f);
        rd(`CBT_OFS_BT0, 8'h01);
    endtask
    // Empty frames: 41 bits plus 10 recessive before the next start
    task automatic t_send;
        logic [7:0] b;
        int ta;
        int tb;
        wr(`CBT_OFS_TXFLG, 8'h07);
        rd(`CBT_OFS_TXFLG, 8'h00);
        frame(b, ta);
        check(b, 8'h20);
        frame(b, tb);
        check(b, 8'h30);
        check(8'(tb - ta > 800 && tb - ta < 832), 8'h01);
        frame(b, tb);
        check(b, 8'h10);
        repeat (600) @(posedge ref_clk_in);
        rd(`CBT_OFS_TXFLG, 8'h07);
    endtask
    // Stamps of back-to-back frames lie 51 bit times apart
    task automatic t_stamp;
        logic [7:0] s1;
        logic [7:0] s2;
        wr(`CBT_OFS_TBSEL, 8'h02);
        peek(6'h1f, s1);
        wr(`CBT_OFS_TBSEL, 8'h04);
        peek(6'h1f, s2);
        check(s2 - s1, 8'h33);
    endtask
    // Lose arbitration on the first identifier bit, then retry
    task automatic t_loss;
        int t;
        wr(`CBT_OFS_TBSEL, 8'h01);
        wr(6'h10, 8'hff);
        wr(`CBT_OFS_TXFLG, 8'h01);
        sof(t);
        repeat (BIT / 2 + 2) @(posedge ref_clk_in);
        clash <= 1'b1;
        repeat (BIT) @(posedge ref_clk_in);
        clash <= 1'b0;
        repeat (BIT * 7 + 5) @(posedge ref_clk_in);
        #1 check({7'h00, can_tx_out}, 8'h01);
        rd(`CBT_OFS_TXFLG, 8'h06);
        repeat (1200) @(posedge ref_clk_in);
        rd(`CBT_OFS_TXFLG, 8'h07);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(posedge ref_clk_in);
        t_reset();
        t_timing();
        t_buffers();
        t_lock();
        t_send();
        t_stamp();
        t_loss();
        conclude();
    end
endmodule
